// >>> hw/ccr_card_regs.sv
module ccr_card_regs
   import ccr_pkg::*;
#(
   parameter logic [DEV_SIZE_W-1:0] DEVICE_SIZE = 22'h000fff,
   parameter logic [3:0] WRITE_BLOCK_LEN = WRITE_BLOCK_LENGTH_VAL,
   parameter logic [7:0] ASYNC_READ_TIME = ASYNC_READ_TIME_VAL
)
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_ce,
   // transport mode pin, asynchronous to i_clk
   input wire logic i_spi_mode_pin,
   // register requests from the command decoder
   input wire logic i_req_valid,
   input wire logic [1:0] i_req_sel,
   input wire logic i_req_write,
   input wire logic [CSD_W-1:0] i_wr_data,
   // address assignment from the card state logic
   input wire logic i_init_done,
   input wire logic i_rca_load,
   input wire logic [RCA_W-1:0] i_rca_value,
   // answers
   output logic o_ready,
   output logic o_rsp_valid,
   output logic o_rsp_refused,
   output logic [CSD_W-1:0] o_rsp_data,
   output logic [RCA_W-1:0] o_rca,
   output logic o_spi_mode
);
   typedef enum logic {ST_LOAD, ST_READY} ccr_state_t;

   ccr_state_t state_reg;
   logic spi_meta_reg;
   logic spi_sync_reg;
   logic fmt_group_reg;
   logic copy_reg;
   logic perm_protect_reg;
   logic temp_protect_reg;
   logic [1:0] fmt_reg;
   logic [1:0] rsv_reg;
   logic [CRC_W-1:0] crc_reg;
   logic once_done_reg;
   logic [RCA_W-1:0] rca_reg;
   logic rsp_valid_reg;
   logic rsp_refused_reg;
   logic [CSD_W-1:0] rsp_data_reg;
   logic [1:0] rsp_sel_reg;
   logic rsp_write_reg;

   logic [CSD_W-1:0] csd_fixed;
   logic [CSD_W-1:0] csd_cur;
   logic [CRC_W-1:0] crc_calc;
   logic take;
   logic take_wr;
   logic ro_match;
   logic once_change;
   logic wr_ok;

   //////////////////////////////////////////////////////////////////////////
   // fixed contents of card_specific_data
   function automatic logic [CSD_W-1:0] csd_build(input logic [15:0] low);
      logic [CSD_W-1:0] v;
      v = '0;
      v[127:126] = CSD_STRUCT_VAL;
      v[125:120] = CSD_RSV_HI_VAL;
      v[ASYNC_TIME_LO +: 8] = ASYNC_READ_TIME;
      v[CLOCKED_TIME_LO +: 8] = CLOCKED_READ_TIME_VAL;
      v[103:96] = TRAN_SPEED_VAL;
      v[95:84] = CMD_CLASS_VAL;
      v[READ_BL_LO +: 4] = READ_BLOCK_LENGTH_VAL;
      v[READ_PARTIAL_BIT] = 1'b0;
      v[WRITE_MISALIGN_BIT] = 1'b0;
      v[READ_MISALIGN_BIT] = 1'b0;
      v[DEV_SIZE_LO +: DEV_SIZE_W] = DEVICE_SIZE;
      v[ERASE_EN_BIT] = 1'b1;
      v[SECTOR_LO +: 7] = ERASE_SECTOR_VAL;
      v[38:32] = PROTECT_GRP_SIZE_VAL;
      v[PROTECT_GRP_BIT] = 1'b0;
      v[28:26] = WRITE_SPEED_FACTOR_VAL;
      v[WRITE_BL_LO +: 4] = WRITE_BLOCK_LEN;
      v[WRITE_PARTIAL_BIT] = 1'b0;
      v[15:0] = low;
      return v;
   endfunction

   assign csd_fixed = csd_build(16'h0001);

   // the reset checksum covers everything above bit 7 with the rewritable bits at zero
   ccr_crc7 u_crc (
      .i_data(csd_fixed[CSD_W-1:8]),
      .o_crc(crc_calc)
   );

   always_comb begin
      csd_cur = csd_fixed;
      csd_cur[FMT_GROUP_BIT] = fmt_group_reg;
      csd_cur[COPY_BIT] = copy_reg;
      csd_cur[PERM_PROTECT_BIT] = perm_protect_reg;
      csd_cur[TEMP_PROTECT_BIT] = temp_protect_reg;
      csd_cur[FMT_LO +: 2] = fmt_reg;
      csd_cur[RSV_LO +: 2] = rsv_reg;
      csd_cur[CRC_LO +: CRC_W] = crc_reg;
      csd_cur[0] = 1'b1;
   end

   //////////////////////////////////////////////////////////////////////////
   // transport mode pin synchroniser
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         spi_meta_reg <= 1'b0;
         spi_sync_reg <= 1'b0;
      end else if (i_ce) begin
         spi_meta_reg <= i_spi_mode_pin;
         spi_sync_reg <= spi_meta_reg;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // one load cycle after reset fills the checksum before requests are taken
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         state_reg <= ST_LOAD;
      end else if (i_ce) begin
         state_reg <= ST_READY;
      end
   end

   assign take = i_ce && i_req_valid && (state_reg == ST_READY);
   assign take_wr = take && i_req_write && (i_req_sel == SEL_CSD);

   // fields above bit 15 must be echoed unchanged, and bit 0 must be one
   assign ro_match = (i_wr_data[CSD_W-1:WRITABLE_LO] == csd_fixed[CSD_W-1:WRITABLE_LO]) && i_wr_data[0];
   assign once_change = (i_wr_data[FMT_GROUP_BIT] != fmt_group_reg)
      || (i_wr_data[COPY_BIT] != copy_reg)
      || (i_wr_data[PERM_PROTECT_BIT] != perm_protect_reg)
      || (i_wr_data[FMT_LO +: 2] != fmt_reg);
   assign wr_ok = ro_match && !(once_done_reg && once_change);

   //////////////////////////////////////////////////////////////////////////
   // rewritable fields
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         temp_protect_reg <= 1'b0;
         rsv_reg <= 2'h0;
         crc_reg <= '0;
      end else if (i_ce) begin
         if (state_reg == ST_LOAD) begin
            crc_reg <= crc_calc;
         end else if (take_wr && wr_ok) begin
            // checksum is stored as written, the host owns its correctness
            temp_protect_reg <= i_wr_data[TEMP_PROTECT_BIT];
            rsv_reg <= i_wr_data[RSV_LO +: 2];
            crc_reg <= i_wr_data[CRC_LO +: CRC_W];
         end
      end
   end

   // fields that lock after their first change
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         fmt_group_reg <= 1'b0;
         copy_reg <= 1'b0;
         perm_protect_reg <= 1'b0;
         fmt_reg <= 2'h0;
         once_done_reg <= 1'b0;
      end else if (i_ce && take_wr && wr_ok) begin
         fmt_group_reg <= i_wr_data[FMT_GROUP_BIT];
         copy_reg <= i_wr_data[COPY_BIT];
         perm_protect_reg <= i_wr_data[PERM_PROTECT_BIT];
         fmt_reg <= i_wr_data[FMT_LO +: 2];
         if (once_change) begin
            once_done_reg <= 1'b1;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // relative address, ignored in serial mode
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         rca_reg <= RCA_RESET_VAL;
      end else if (i_ce && i_init_done && i_rca_load && !spi_sync_reg) begin
         rca_reg <= i_rca_value;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // answer one cycle after the request is taken
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         rsp_valid_reg <= 1'b0;
         rsp_refused_reg <= 1'b0;
         rsp_data_reg <= '0;
         rsp_sel_reg <= SEL_CSD;
         rsp_write_reg <= 1'b0;
      end else if (i_ce) begin
         rsp_valid_reg <= take;
         if (take) begin
            rsp_sel_reg <= i_req_sel;
            rsp_write_reg <= i_req_write;
            rsp_refused_reg <= 1'b0;
            rsp_data_reg <= '0;
            if (i_req_write) begin
               // only card_specific_data accepts writes
               rsp_refused_reg <= !((i_req_sel == SEL_CSD) && wr_ok);
            end else begin
               unique case (i_req_sel)
                  SEL_CSD: rsp_data_reg <= csd_cur;
                  SEL_SCR: rsp_data_reg[SCR_W-1:0] <= CARD_CONFIG_VAL;
                  SEL_RCA: begin
                     if (spi_sync_reg) begin
                        rsp_refused_reg <= 1'b1;
                     end else begin
                        rsp_data_reg[RCA_W-1:0] <= rca_reg;
                     end
                  end
                  default: rsp_refused_reg <= 1'b1;
               endcase
            end
         end
      end
   end

   assign o_ready = (state_reg == ST_READY);
   assign o_rsp_valid = rsp_valid_reg;
   assign o_rsp_refused = rsp_refused_reg;
   assign o_rsp_data = rsp_data_reg;
   assign o_rca = rca_reg;
   assign o_spi_mode = spi_sync_reg;

   //////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_reset);

   logic csd_read_rsp;
   assign csd_read_rsp = rsp_valid_reg && !rsp_refused_reg && !rsp_write_reg && (rsp_sel_reg == SEL_CSD);

   sequence seq_csd_write;
      take_wr && wr_ok;
   endsequence

   sequence seq_csd_read;
      i_ce && i_req_valid && o_ready && !i_req_write && (i_req_sel == SEL_CSD);
   endsequence

   chk_answer_timing: assert property (take |=> o_rsp_valid)
      else $error("answer missing one cycle after request");

   chk_no_stray_answer: assert property (i_ce && !take |=> !o_rsp_valid)
      else $error("answer without request");

   chk_device_size: assert property (csd_read_rsp |-> o_rsp_data[69:48] == DEVICE_SIZE)
      else $error("device size field wrong");

   chk_fixed_fields: assert property (csd_read_rsp |-> o_rsp_data[119:112] == ASYNC_READ_TIME
      && o_rsp_data[111:104] == 8'h00 && o_rsp_data[83:77] == 7'h48 && o_rsp_data[46:39] == 8'hff
      && !o_rsp_data[31] && o_rsp_data[25:22] == WRITE_BLOCK_LEN && !o_rsp_data[21] && o_rsp_data[0])
      else $error("fixed card data field wrong");

   chk_once_lock: assert property (take_wr && once_done_reg && once_change |=> o_rsp_refused
      && $stable(fmt_group_reg) && $stable(perm_protect_reg) && $stable(fmt_reg))
      else $error("locked field changed twice");

   // the host leaves one idle cycle between requests, so the read lands two cycles after the write
   chk_rewrite_read: assert property (seq_csd_write ##2 (!i_req_write && take && i_req_sel == SEL_CSD)
      |=> o_rsp_data[12] == $past(i_wr_data[12], 3) && o_rsp_data[7:1] == $past(i_wr_data[7:1], 3))
      else $error("rewritten field not returned");

   chk_read_after_load: assert property (seq_csd_read |=> o_rsp_data[CSD_W-1:16] == csd_fixed[CSD_W-1:16])
      else $error("read-only card data changed");

   chk_crc_load: assert property (state_reg == ST_LOAD && i_ce |=> crc_reg == $past(crc_calc))
      else $error("reset checksum not loaded");

   chk_config_bits: assert property (rsp_valid_reg && !rsp_write_reg && rsp_sel_reg == SEL_SCR
      |-> o_rsp_data[55] && o_rsp_data[33:32] == 2'h3 && o_rsp_data[127:64] == '0)
      else $error("configuration bits wrong");

   chk_rca_serial: assert property (take && !i_req_write && i_req_sel == SEL_RCA && spi_sync_reg
      |=> o_rsp_refused && o_rsp_data == '0)
      else $error("address register served in serial mode");

   chk_rca_hold: assert property (!i_init_done || spi_sync_reg |=> $stable(rca_reg))
      else $error("address changed before init");
endmodule

// >>> hw/ccr_crc7.sv
// serial checksum unrolled into one combinational pass, msb first
module ccr_crc7
   import ccr_pkg::*;
(
   // data
   input wire logic [CRC_DATA_W-1:0] i_data,
   // checksum
   output logic [CRC_W-1:0] o_crc
);
   always_comb begin
      logic [CRC_W-1:0] c;
      logic fb;
      c = '0;
      fb = 1'b0;
      for (int i = CRC_DATA_W - 1; i >= 0; i--) begin
         fb = i_data[i] ^ c[CRC_W-1];
         c = {c[CRC_W-2:0], 1'b0};
         if (fb) begin
            c = c ^ CRC_POLY;
         end
      end
      o_crc = c;
   end
endmodule

// >>> pkg/ccr_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Function
// - 22-bit device size at bits 69:48
// - host may rewrite bits 12, 9:8, 7:1
// - bits 15, 14, 13, 11:10 change once only
// - 7-bit checksum in 7:1, bit 0 one
// - async read time code at 119:112
// - clocked read time at 111:104, zero
// - read block length 83:80 is 1001
// - bits 79, 78, 77 read as zero
// - bit 46 one, bits 45:39 all ones
// - protect group enable bit 31 zero
// - write block length at 25:22
// - partial write bit 21 zero
// - erased data all ones, config bit 55
// - config bits 33:32 read 11
// - 16-bit address, zero, set after init
// - no address register in serial mode
//////////////////////////////////////////////////////////////////////////////
package ccr_pkg;
   localparam int CSD_W = 128;
   localparam int SCR_W = 64;
   localparam int RCA_W = 16;
   localparam int CRC_W = 7;
   localparam int CRC_DATA_W = 120;
   localparam logic [6:0] CRC_POLY = 7'h09;

   // request selectors
   localparam logic [1:0] SEL_CSD = 2'h0;
   localparam logic [1:0] SEL_SCR = 2'h1;
   localparam logic [1:0] SEL_RCA = 2'h2;

   // card_specific_data field values
   localparam logic [1:0] CSD_STRUCT_VAL = 2'h1;
   localparam logic [5:0] CSD_RSV_HI_VAL = 6'h00;
   localparam logic [7:0] ASYNC_READ_TIME_VAL = 8'h0e;
   localparam logic [7:0] CLOCKED_READ_TIME_VAL = 8'h00;
   localparam logic [7:0] TRAN_SPEED_VAL = 8'h32;
   localparam logic [11:0] CMD_CLASS_VAL = 12'h5b5;
   localparam logic [3:0] READ_BLOCK_LENGTH_VAL = 4'h9;
   localparam logic [3:0] WRITE_BLOCK_LENGTH_VAL = 4'h9;
   localparam logic [6:0] ERASE_SECTOR_VAL = 7'h7f;
   localparam logic [6:0] PROTECT_GRP_SIZE_VAL = 7'h00;
   localparam logic [2:0] WRITE_SPEED_FACTOR_VAL = 3'h2;

   // card_specific_data field positions
   localparam int ASYNC_TIME_LO = 112;
   localparam int CLOCKED_TIME_LO = 104;
   localparam int READ_BL_LO = 80;
   localparam int READ_PARTIAL_BIT = 79;
   localparam int WRITE_MISALIGN_BIT = 78;
   localparam int READ_MISALIGN_BIT = 77;
   localparam int DEV_SIZE_LO = 48;
   localparam int DEV_SIZE_W = 22;
   localparam int ERASE_EN_BIT = 46;
   localparam int SECTOR_LO = 39;
   localparam int PROTECT_GRP_BIT = 31;
   localparam int WRITE_BL_LO = 22;
   localparam int WRITE_PARTIAL_BIT = 21;
   localparam int FMT_GROUP_BIT = 15;
   localparam int COPY_BIT = 14;
   localparam int PERM_PROTECT_BIT = 13;
   localparam int TEMP_PROTECT_BIT = 12;
   localparam int FMT_LO = 10;
   localparam int RSV_LO = 8;
   localparam int CRC_LO = 1;
   localparam int WRITABLE_LO = 16;

   // card_configuration
   localparam logic [63:0] CARD_CONFIG_VAL = 64'h02b5_8003_0000_0000;
   localparam int ERASED_ONES_BIT = 55;
   localparam int OPT_CMD_LO = 32;
   localparam logic [1:0] OPT_CMD_VAL = 2'h3;

   localparam logic [15:0] RCA_RESET_VAL = 16'h0000;
endpackage

// >>> verification/card_config_register_set_test.sv
module card_config_register_set_test;
   import ccr_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [DEV_SIZE_W-1:0] DSIZE = 22'h2a5c3;
   localparam logic [3:0] WBL = 4'ha;
   logic i_clk, i_reset, i_ce, i_spi_mode_pin, i_init_done, i_rca_load;
   logic [RCA_W-1:0] i_rca_value, addr;
   logic req_valid, req_write, o_ready, o_rsp_valid, o_rsp_refused, o_spi_mode, refd;
   logic [1:0] req_sel;
   logic [CSD_W-1:0] wr_data, o_rsp_data, card_specific_data, img, rd;
   logic [RCA_W-1:0] o_rca;
   logic [31:0] seed;
   int mismatches, checks, cycles;
   ccr_card_regs #(.DEVICE_SIZE(DSIZE), .WRITE_BLOCK_LEN(WBL), .ASYNC_READ_TIME(ASYNC_READ_TIME_VAL)) uut (
      .i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce), .i_spi_mode_pin(i_spi_mode_pin),
      .i_req_valid(req_valid), .i_req_sel(req_sel), .i_req_write(req_write), .i_wr_data(wr_data),
      .i_init_done(i_init_done), .i_rca_load(i_rca_load), .i_rca_value(i_rca_value),
      .o_ready(o_ready), .o_rsp_valid(o_rsp_valid), .o_rsp_refused(o_rsp_refused),
      .o_rsp_data(o_rsp_data), .o_rca(o_rca), .o_spi_mode(o_spi_mode));
   ccr_host_model host (
      .i_clk(i_clk), .i_ready(o_ready), .i_rsp_valid(o_rsp_valid), .i_rsp_refused(o_rsp_refused),
      .i_rsp_data(o_rsp_data), .o_req_valid(req_valid), .o_req_sel(req_sel),
      .o_req_write(req_write), .o_wr_data(wr_data));
   //////////////////////////////////////////////////////////////////////////
   initial begin
      i_clk = 1'h0;
      forever #2.5 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         print_verdict();
      end
   end
   //////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   // checksum over 127:8 as it stands, msb first
   function automatic logic [6:0] crc7(input logic [CSD_W-1:0] d);
      logic [6:0] c;
      logic fb;
      c = 7'h00;
      for (int i = 127; i >= 8; i--) begin
         fb = d[i] ^ c[6];
         c = {c[5:0], 1'h0};
         if (fb) c ^= CRC_POLY;
      end
      return c;
   endfunction
   task automatic check(input logic [CSD_W-1:0] seen, input logic [CSD_W-1:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rq(input logic [1:0] sel, input logic wr, input logic [CSD_W-1:0] data);
      host.issue(sel, wr, data, refd, rd);
   endtask
   task automatic wr_img();
      img[7:1] = crc7(img);
      rq(SEL_CSD, 1'h1, img);
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   //////////////////////////////////////////////////////////////////////////
   initial begin
      i_reset = 1'h1;
      i_ce = 1'h1;
      i_spi_mode_pin = 1'h0;
      i_init_done = 1'h0;
      i_rca_load = 1'h0;
      i_rca_value = 16'h0000;
      seed = 32'h12e5;
      repeat (5) @(posedge i_clk);
      #1;
      i_reset = 1'h0;
      @(posedge i_clk);
      #1;
      check(o_ready, 1'h1);
      check(o_rca, RCA_RESET_VAL);
      rq(SEL_CSD, 1'h0, '0);
      card_specific_data = rd;
      check(refd, 1'h0);
      check(card_specific_data[119:112], 8'h0e);
      check(card_specific_data[111:104], 8'h00);
      check(card_specific_data[83:80], 4'h9);
      check(card_specific_data[79:77], 3'h0);
      check(card_specific_data[69:48], DSIZE);
      check(card_specific_data[46:39], 8'hff);
      check(card_specific_data[31], 1'h0);
      check(card_specific_data[25:22], WBL);
      check(card_specific_data[21], 1'h0);
      check({card_specific_data[15:8], card_specific_data[7:0]}, {8'h00, crc7(card_specific_data), 1'h1});
      rq(SEL_SCR, 1'h0, '0);
      check(rd[55], 1'h1);
      check({rd[127:64], rd[33:32]}, {64'h0, 2'h3});
      // random rewrites of the freely writable fields, each read straight back
      for (int k = 0; k < 8; k++) begin
         seed = xs(seed);
         img = card_specific_data;
         img[12] = seed[0];
         img[9:8] = seed[2:1];
         wr_img();
         check(refd, 1'h0);
         card_specific_data = img;
         rq(SEL_CSD, 1'h0, '0);
         check(rd, card_specific_data);
      end
      img[14] = 1'h1;
      wr_img();
      check(refd, 1'h0);
      card_specific_data = img;
      img[15] = 1'h1;
      wr_img();
      check(refd, 1'h1);
      rq(SEL_CSD, 1'h0, '0);
      check(rd, card_specific_data);
      img = card_specific_data;
      img[12] = ~img[12];
      wr_img();
      check(refd, 1'h0);
      card_specific_data = img;
      img[DEV_SIZE_LO] = ~img[DEV_SIZE_LO];
      wr_img();
      check(refd, 1'h1);
      img = card_specific_data;
      img[0] = 1'h0;
      rq(SEL_CSD, 1'h1, img);
      check(refd, 1'h1);
      rq(SEL_SCR, 1'h1, card_specific_data);
      check(refd, 1'h1);
      rq(2'h3, 1'h0, '0);
      check(refd, 1'h1);
      rq(SEL_CSD, 1'h0, '0);
      check(rd, card_specific_data);
      // address: held until initialisation is done
      addr = seed[15:0] | 16'h0001;
      i_rca_value = addr;
      i_rca_load = 1'h1;
      repeat (3) @(posedge i_clk);
      #1;
      check(o_rca, 16'h0000);
      i_init_done = 1'h1;
      repeat (2) @(posedge i_clk);
      #1;
      i_rca_load = 1'h0;
      check(o_rca, addr);
      rq(SEL_RCA, 1'h0, '0);
      check({refd, rd}, {1'h0, 112'h0, addr});
      // the mode pin needs two enabled edges through the synchroniser before it blocks loads
      i_spi_mode_pin = 1'h1;
      repeat (3) @(posedge i_clk);
      #1;
      i_rca_value = ~addr;
      i_rca_load = 1'h1;
      repeat (2) @(posedge i_clk);
      #1;
      check({o_spi_mode, o_rca}, {1'h1, addr});
      rq(SEL_RCA, 1'h0, '0);
      check({refd, rd}, {1'h1, 128'h0});
      // clock enable low freezes the synchroniser
      i_ce = 1'h0;
      i_spi_mode_pin = 1'h0;
      repeat (4) @(posedge i_clk);
      #1;
      check(o_spi_mode, 1'h1);
      i_ce = 1'h1;
      print_verdict();
   end
endmodule

// >>> verification/ccr_host_model.sv
module ccr_host_model
   import ccr_pkg::*;
(
   // clock and card answers
   input wire logic i_clk,
   input wire logic i_ready,
   input wire logic i_rsp_valid,
   input wire logic i_rsp_refused,
   input wire logic [CSD_W-1:0] i_rsp_data,
   // requests to the card
   output logic o_req_valid,
   output logic [1:0] o_req_sel,
   output logic o_req_write,
   output logic [CSD_W-1:0] o_wr_data
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      o_req_valid = 1'h0;
      o_req_sel = 2'h0;
      o_req_write = 1'h0;
      o_wr_data = '0;
   end
   //////////////////////////////////////////////////////////////////////////
   // one request held until taken, answer sampled settled after an edge
   task automatic issue(input logic [1:0] sel, input logic wr, input logic [CSD_W-1:0] data,
                        output logic refused, output logic [CSD_W-1:0] rdata);
      int n;
      @(posedge i_clk);
      #1;
      o_req_valid = 1'h1;
      o_req_sel = sel;
      o_req_write = wr;
      o_wr_data = data;
      n = 0;
      do begin
         @(posedge i_clk);
         n++;
      end while (i_ready !== 1'h1 && n < 20);
      #1;
      // idle lines flip so a stale request image is never mistaken for a new one
      o_req_valid = 1'h0;
      o_req_sel = ~sel;
      o_req_write = ~wr;
      o_wr_data = ~data;
      n = 0;
      while (i_rsp_valid !== 1'h1 && n < 4) begin
         @(posedge i_clk);
         #1;
         n++;
      end
      refused = (n < 4) ? i_rsp_refused : 1'hx;
      rdata = i_rsp_data;
   endtask
endmodule
